// >>> bench/host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  input  wire logic       clk_in,
  input  wire logic       ds_mode_in,
  input  wire logic [7:0] dev_data_in,
  input  wire logic       dev_oe_in,
  output logic      [7:0] bus_out,
  output logic            latch_out,
  output logic            strobe_out,
  output logic            dir_out,
  output logic            sel_n_out
);
  // ------
  // host side of one bus cycle
  // ------
  logic [7:0] drv_d = 8'h00;
  logic       drv_on = 1'b0;
  logic       act = 1'b0;
  logic       rd = 1'b1;
  initial
  begin
    latch_out = 1'b0;
    sel_n_out = 1'b1;
  end
  // released bus shows the inverse of the last value
  assign bus_out    = dev_oe_in ? dev_data_in : (drv_on ? drv_d : ~drv_d);
  assign strobe_out = ds_mode_in ? act : !(act && rd);
  assign dir_out    = ds_mode_in ? rd : !(act && !rd);
  task automatic cycle(input logic r, input logic [7:0] a, input logic [7:0] d, input logic s,
                       output logic [7:0] q);
    @(posedge clk_in);
    latch_out <= 1'b1;
    drv_d <= a;
    drv_on <= 1'b1;
    repeat (2) @(posedge clk_in);
    latch_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    drv_d <= d;
    drv_on <= !r;
    rd <= r;
    sel_n_out <= s;
    @(posedge clk_in);
    act <= 1'b1;
    repeat (6) @(posedge clk_in);
    q = bus_out;
    act <= 1'b0;
    repeat (3) @(posedge clk_in);
    sel_n_out <= 1'b1;
    drv_on <= 1'b0;
    repeat (5) @(posedge clk_in);
  endtask
endmodule : host_bus_model
`default_nettype wire

// >>> bench/rtc_muxed_bus_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_muxed_bus_port_tb_top;
  typedef struct packed {logic rd; logic [7:0] a; logic [7:0] d;} row_s;
  logic       clk_in = 1'b0;
  logic       nrst_in = 1'b0;
  logic       strap = 1'b0;
  logic [7:0] bus, dout, q;
  logic       oe, as_s, ds_s, dir_s, sel_n, mode, ctrl;
  logic [6:0] la;
  logic [7:0] mem [128];
  int         err_total = 0;
  int         num_checks = 0;
  row_s       rows [8] = '{'{1'b0, 8'h00, 8'h5a}, '{1'b0, 8'h7f, 8'ha5}, '{1'b0, 8'h8d, 8'h3c},
                           '{1'b0, 8'h0e, 8'h77}, '{1'b1, 8'h00, 8'h00}, '{1'b1, 8'hff, 8'h00},
                           '{1'b1, 8'h0d, 8'h00}, '{1'b1, 8'h0e, 8'h00}};
  always #25 clk_in = ~clk_in;
  host_bus_model host_bus_model_inst (.clk_in(clk_in), .ds_mode_in(strap), .dev_data_in(dout),
    .dev_oe_in(oe), .bus_out(bus), .latch_out(as_s), .strobe_out(ds_s), .dir_out(dir_s),
    .sel_n_out(sel_n));
  rtc_muxed_bus_port rtc_muxed_bus_port_inst (.clk_in(clk_in), .nrst_in(nrst_in),
    .shared_addr_data_bus_in(bus), .shared_addr_data_bus_out(dout), .shared_addr_data_bus_oe_out(oe),
    .address_latch_strobe_in(as_s), .data_phase_strobe_in(ds_s), .direction_in(dir_s),
    .select_n_in(sel_n), .bus_style_strap_in(strap), .latched_addr_out(la), .ctrl_space_out(ctrl),
    .mode_data_strobe_out(mode));
  // ------
  // checking
  // ------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (err_total == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic run(input row_s r, input logic s);
    host_bus_model_inst.cycle(r.rd, r.a, r.d, s, q);
    check({1'b0, la}, {1'b0, r.a[6:0]});
    check({7'h00, ctrl}, {7'h00, r.a[6:0] < 7'h0e});
    check({7'h00, oe}, 8'h00);
    if (r.rd)
      check(q, mem[r.a[6:0]]);
    else if (!s)
      mem[r.a[6:0]] = r.d;
  endtask
  task automatic restart(input logic st);
    nrst_in <= 1'b0;
    strap <= st;
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    check({6'h00, oe, mode}, {6'h00, 1'b0, st});
  endtask
  // ------
  // sequence
  // ------
  initial
  begin
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    check({mode, la}, 8'h00);
    foreach (rows[i]) run(rows[i], 1'b0);
    run('{1'b0, 8'h0e, 8'h11}, 1'b1);
    run('{1'b1, 8'h0e, 8'h00}, 1'b0);
    restart(1'b1);
    run('{1'b0, 8'h33, 8'hc3}, 1'b0);
    run('{1'b1, 8'hb3, 8'h00}, 1'b0);
    restart(1'b0);
    run('{1'b1, 8'h33, 8'h00}, 1'b0);
    print_verdict();
  end
  // watchdog well beyond the roughly 300 cycles of the sequence
  initial
  begin
    #250000;
    err_total++;
    print_verdict();
  end
endmodule : rtc_muxed_bus_port_tb_top
`default_nettype wire

// >>> core/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule // pin_sync
`default_nettype wire

// >>> core/rtc_muxed_bus_port.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - falling address-latch strobe captures bus bits 0..6 as address.
// - 128 byte locations: 14 control registers, rest general RAM.
// - data-strobe mode captures write data on data strobe fall.
// - reads drive all eight bits during the read strobe.
// - read ends on data strobe fall or read strobe rise.
// - data-strobe mode drives read data only while strobe high.
// - split-strobe mode: strobe pin is active-low read enable.
// - strap high selects data-strobe mode, low or open split-strobe.
// - variants without strap run permanently in split-strobe mode.
// - split-strobe mode: direction pin is active-low write strobe.
// - device select low throughout strobe, else no access; a read drives only in cycles with select low, a write checks select only in the cycle its strobe ends.
module rtc_muxed_bus_port #(
  parameter bit HAS_STRAP = 1'b1
) (
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic [7:0] shared_addr_data_bus_in,
  output logic      [7:0] shared_addr_data_bus_out,
  output logic            shared_addr_data_bus_oe_out,
  input  wire logic       address_latch_strobe_in,
  input  wire logic       data_phase_strobe_in,
  input  wire logic       direction_in,
  input  wire logic       select_n_in,
  input  wire logic       bus_style_strap_in,
  output logic [6:0]      latched_addr_out,
  output logic            ctrl_space_out,
  output logic            mode_data_strobe_out
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [7:0] bus_s;
  logic [4:0] ctl_s;

  pin_sync #(.WIDTH(8)) u_bus_sync (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .async_in (shared_addr_data_bus_in),
    .sync_out (bus_s)
  );

  pin_sync #(.WIDTH(5)) u_ctl_sync (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .async_in ({bus_style_strap_in, select_n_in, direction_in,
                data_phase_strobe_in, address_latch_strobe_in}),
    .sync_out (ctl_s)
  );

  logic as_s, ds_s, dir_s, sel_n_s, strap_s;
  assign as_s    = ctl_s[0];
  assign ds_s    = ctl_s[1];
  assign dir_s   = ctl_s[2];
  assign sel_n_s = ctl_s[3];
  assign strap_s = ctl_s[4];

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic       as_d;
    logic       ds_d;
    logic       dir_d;
    logic       mode_ds;
    logic       strap_done;
    logic [1:0] strap_wait;
    logic [6:0] addr;
    logic [7:0] dout;
    logic       oe;
  } port_s;

  logic [7:0] mem [rtc_port_pkg::LOC_COUNT];
  port_s state_reg;
  port_s state_next;
  logic  wr_en;

  logic read_active;
  logic write_fire;

  always_comb
  begin
    state_next       = state_reg;
    state_next.as_d  = as_s;
    state_next.ds_d  = ds_s;
    state_next.dir_d = dir_s;
    read_active      = 1'b0;
    write_fire       = 1'b0;
    // strap sampled once the synchronisers have flushed
    if (!state_reg.strap_done)
    begin
      if (state_reg.strap_wait == rtc_port_pkg::STRAP_SETTLE)
      begin
        state_next.strap_done = 1'b1;
        state_next.mode_ds    = HAS_STRAP && (strap_s == rtc_port_pkg::STRAP_DATA_STROBE);
      end
      else
      begin
        state_next.strap_wait = state_reg.strap_wait + 2'h1;
      end
    end
    // bit 7 dropped on address capture
    if (state_reg.as_d && !as_s)
    begin
      state_next.addr = bus_s[6:0];
    end
    // no access until the strap has settled
    if (state_reg.strap_done && state_reg.mode_ds)
    begin
      read_active = ds_s && dir_s && !sel_n_s;
      write_fire  = state_reg.ds_d && !ds_s && !state_reg.dir_d && !sel_n_s;
    end
    else if (state_reg.strap_done)
    begin
      read_active = !ds_s && !sel_n_s;
      write_fire  = !state_reg.dir_d && dir_s && !sel_n_s;
    end
    state_next.oe = read_active;
    if (read_active)
    begin
      state_next.dout = mem[state_reg.addr];
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      state_reg <= '{as_d: 1'b0, ds_d: 1'b0, dir_d: 1'b1, mode_ds: 1'b0, strap_done: 1'b0, strap_wait: 2'h0,
                     addr: rtc_port_pkg::ADDR_RESET, dout: rtc_port_pkg::DATA_RESET, oe: 1'b0};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // data held from the last sample before the write strobe ends
  logic [7:0] wdata_reg;
  always_ff @(posedge clk_in)
  begin
    wdata_reg <= bus_s;
  end

  assign wr_en = write_fire && state_reg.strap_done;
  always_ff @(posedge clk_in)
  begin
    if (wr_en)
    begin
      mem[state_reg.addr] <= wdata_reg;
    end
  end

  assign shared_addr_data_bus_out    = state_reg.dout;
  assign shared_addr_data_bus_oe_out = state_reg.oe;
  assign latched_addr_out            = state_reg.addr;
  assign ctrl_space_out              = ({25'h0, state_reg.addr} < rtc_port_pkg::CTRL_REG_COUNT);
  assign mode_data_strobe_out        = state_reg.mode_ds;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_addr_capture;
    @(posedge clk_in) disable iff (!nrst_in)
    (state_reg.as_d && !as_s) |=> (state_reg.addr == $past(bus_s[6:0]));
  endproperty
  a_addr_capture: assert property (p_addr_capture) else $error("address not latched");

  property p_oe_ds;
    @(posedge clk_in) disable iff (!nrst_in)
    (state_reg.mode_ds && !ds_s) |=> !state_reg.oe;
  endproperty
  a_oe_ds: assert property (p_oe_ds) else $error("bus driven with strobe low");

  property p_oe_rd;
    @(posedge clk_in) disable iff (!nrst_in)
    (!state_reg.mode_ds && state_reg.strap_done && ds_s) |=> !state_reg.oe;
  endproperty
  a_oe_rd: assert property (p_oe_rd) else $error("bus driven after read strobe");

  property p_sel;
    @(posedge clk_in) disable iff (!nrst_in)
    sel_n_s |=> !state_reg.oe;
  endproperty
  a_sel: assert property (p_sel) else $error("access without select");

  property p_nostrap;
    @(posedge clk_in) disable iff (!nrst_in)
    !HAS_STRAP |-> !state_reg.mode_ds;
  endproperty
  a_nostrap: assert property (p_nostrap) else $error("mode without strap");

  sequence s_read_req;
    state_reg.strap_done && !sel_n_s &&
    (state_reg.mode_ds ? (ds_s && dir_s) : !ds_s);
  endsequence

  property p_read_drive;
    @(posedge clk_in) disable iff (!nrst_in)
    s_read_req |=> (state_reg.oe && (state_reg.dout == $past(mem[state_reg.addr])));
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read data not driven");

  property p_write_store;
    @(posedge clk_in) disable iff (!nrst_in)
    wr_en |=> (mem[$past(state_reg.addr)] == $past(wdata_reg));
  endproperty
  a_write_store: assert property (p_write_store) else $error("write data not stored");

  property p_write_once;
    @(posedge clk_in) disable iff (!nrst_in)
    wr_en |=> !wr_en;
  endproperty
  a_write_once: assert property (p_write_once) else $error("write repeated in one strobe");
endmodule // rtc_muxed_bus_port
`default_nettype wire

// >>> core/rtc_port_pkg.sv
package rtc_port_pkg;
  // ----------------------------------------
  // address space
  // ----------------------------------------
  localparam int unsigned LOC_COUNT      = 128;
  localparam int unsigned CTRL_REG_COUNT = 14;
  localparam int unsigned ADDR_BITS      = 7;
  localparam int unsigned DATA_BITS      = 8;
  localparam logic [6:0]  ADDR_RESET     = 7'h00;
  localparam logic [7:0]  DATA_RESET     = 8'h00;
  // ----------------------------------------
  // strap encoding
  // ----------------------------------------
  localparam logic        STRAP_DATA_STROBE  = 1'b1;
  localparam logic        STRAP_SPLIT_STROBE = 1'b0;
  localparam logic [1:0]  STRAP_SETTLE       = 2'h2;
endpackage : rtc_port_pkg
